// ---- verilog/pri_pkg.sv ----
/*
  Shared constants for the regulator-controller serial port: the bus
  address, byte geometry, operating modes and link clock divider figures.
  Assumes both ends run on one 25 MHz system clock.
*/
`default_nettype none
package pri_pkg;
  localparam logic [6:0] DEV_ADDR      = 7'h61;
  localparam int         BYTE_BITS     = 8;
  localparam int         REG_COUNT     = 32;
  localparam int         REG_AW        = 5;
  localparam int         SYS_CLK_HZ    = 25000000;
  localparam int         LINK_RATE_HZ  = 100000;
  // Half period of the serial clock made by the master, in system cycles
  localparam int         HALF_CYCLES   = SYS_CLK_HZ / (2 * LINK_RATE_HZ);
  localparam int         OTP_LOAD_CYCLES = 4;
  localparam logic [7:0] OTP_DEFAULT   = 8'h00;
  typedef enum logic [1:0] {PRI_SHUTDOWN, PRI_OTP_LOAD, PRI_STANDBY, PRI_ACTIVE} pri_mode_t;
endpackage
`default_nettype wire

// ---- verilog/pri_link_if.sv ----
/*
  Two-wire link between the master and the slave port.
  Open-drain: each party gives an output and an enable, enable low means
  driving low; the wire is high unless some party pulls it.
*/
`timescale 1ns/1ps
`default_nettype none
interface pri_link_if;
  logic scl_o_m;
  logic scl_oe_n_m;
  logic sda_o_m;
  logic sda_oe_n_m;
  logic sda_o_s;
  logic sda_oe_n_s;
  wire  scl;
  wire  sda;
  // Pull-ups; clock driven by the master only, data a wired-AND of both parties
  assign scl = scl_oe_n_m ? 1'b1 : scl_o_m;
  assign sda = (sda_oe_n_m ? 1'b1 : sda_o_m) & (sda_oe_n_s ? 1'b1 : sda_o_s);
  modport master (input scl, input sda, output scl_o_m, output scl_oe_n_m, output sda_o_m, output sda_oe_n_m);
  modport slave  (input scl, input sda, output sda_o_s, output sda_oe_n_s);
endinterface
`default_nettype wire

// ---- verilog/pri_slave.sv ----
/*
  Device end: serial register port of a power-management controller, with
  its operating mode sequencer. Samples the link pins on sys_clk.
  Assumes the link runs well below a quarter of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pri_slave
  import pri_pkg::*;
#(
  parameter int OTP_CYCLES = OTP_LOAD_CYCLES
) (
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  input  wire logic           supply_ok,
  input  wire logic [7:0]     otp_data,
  input  wire logic [7:0]     otp_mask,
  input  wire logic [7:0]     reg_enables_idx,
  output logic                regs_enabled,
  output var pri_mode_t       mode,
  output logic [REG_AW-1:0]   otp_idx,
  pri_link_if.slave           link
);
  typedef enum {ST_IDLE, ST_ADDR, ST_INDEX, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK, ST_IGNORE} pri_st_t;

  logic [7:0]        regs [REG_COUNT];
  logic [2:0]        scl_s;
  logic [2:0]        sda_s;
  logic              scl_q;
  logic              sda_q;
  pri_st_t           st;
  pri_st_t           after_ack;
  logic [3:0]        bitn;
  logic [7:0]        shreg;
  logic [REG_AW-1:0] index;
  logic              drive_low;
  logic [2:0]        sup_s;
  logic              sup_q;
  logic [$clog2(REG_COUNT+OTP_CYCLES+1)-1:0] ocnt;

  // Level moves once stages two and three agree
  function automatic logic settle(input logic [2:0] s, input logic held);
    return (s[1] == s[2]) ? s[2] : held;
  endfunction

  // Stable levels of the pins and the supply monitor
  wire scl_n  = settle(scl_s, scl_q);
  wire sda_n  = settle(sda_s, sda_q);
  wire sup_n  = settle(sup_s, sup_q);
  wire scl_re = scl_n & ~scl_q;
  wire scl_fe = ~scl_n & scl_q;
  wire start_c = scl_n & scl_q & sda_q & ~sda_n;
  wire stop_c  = scl_n & scl_q & ~sda_q & sda_n;
  wire link_ok = (mode == PRI_STANDBY) || (mode == PRI_ACTIVE);
  wire any_on  = |regs[reg_enables_idx[REG_AW-1:0]][1:0];
  wire addr_hit = (shreg[7:1] == DEV_ADDR);

  // Pin and supply synchronisers, three stages
  // sampling needs the link well below a quarter of sys_clk
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      sup_s <= 3'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sup_q <= 1'b0;
    end else begin
      scl_s <= {scl_s[1:0], link.scl};
      sda_s <= {sda_s[1:0], link.sda};
      sup_s <= {sup_s[1:0], supply_ok};
      scl_q <= scl_n;
      sda_q <= sda_n;
      sup_q <= sup_n;
    end
  end

  // Mode sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= PRI_SHUTDOWN;
      ocnt <= '0;
    end else if (!sup_n) begin
      mode <= PRI_SHUTDOWN;
      ocnt <= '0;
    end else begin
      case (mode)
        PRI_SHUTDOWN: mode <= PRI_OTP_LOAD;
        PRI_OTP_LOAD: begin
          // stay here until all defaults loaded
          ocnt <= ocnt + 1'b1;
          if (ocnt == ($bits(ocnt))'(REG_COUNT - 1))
            mode <= PRI_STANDBY;
        end
        PRI_STANDBY:  if (any_on) mode <= PRI_ACTIVE;
        PRI_ACTIVE:   if (!any_on) mode <= PRI_STANDBY;
        default:      mode <= PRI_SHUTDOWN;
      endcase
    end
  end

  assign otp_idx      = ocnt[REG_AW-1:0];
  assign regs_enabled = (mode == PRI_ACTIVE);

  // Serial protocol engine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= ST_IDLE;
      after_ack <= ST_IDLE;
      bitn      <= '0;
      shreg     <= '0;
      index     <= '0;
      drive_low <= 1'b0;
    end else if (!link_ok || stop_c) begin
      st        <= ST_IDLE;
      drive_low <= 1'b0;
    end else if (start_c) begin
      // Repeated start keeps the index for the read phase
      st        <= ST_ADDR;
      bitn      <= '0;
      drive_low <= 1'b0;
    end else begin
      case (st)
        ST_ADDR, ST_INDEX, ST_WDATA: begin
          if (scl_re) begin
            shreg <= {shreg[6:0], sda_n};
            bitn  <= bitn + 1'b1;
          end
          if (scl_fe && bitn == 4'(BYTE_BITS)) begin
            bitn <= '0;
            drive_low <= 1'b1;
            st        <= ST_ACK;
            case (st)
              ST_ADDR: begin
                if (!addr_hit) begin
                  drive_low <= 1'b0;
                  st        <= ST_IGNORE;
                end else if (shreg[0]) begin
                  after_ack <= ST_RDATA;
                  shreg     <= regs[index];
                end else begin
                  after_ack <= ST_INDEX;
                end
              end
              ST_INDEX: begin
                index     <= shreg[REG_AW-1:0];
                after_ack <= ST_WDATA;
              end
              default: begin
                index     <= index + 1'b1;
                after_ack <= ST_WDATA;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fe) begin
            drive_low <= (after_ack == ST_RDATA) ? ~shreg[7] : 1'b0;
            st        <= after_ack;
          end
        end
        ST_RDATA: begin
          if (scl_re)
            bitn <= bitn + 1'b1;
          if (scl_fe) begin
            if (bitn == 4'(BYTE_BITS)) begin
              drive_low <= 1'b0;
              st        <= ST_RACK;
            end else begin
              shreg     <= {shreg[6:0], 1'b0};
              drive_low <= ~shreg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_re) begin
            bitn <= '0;
            shreg <= regs[index];
            st    <= sda_n ? ST_IGNORE : ST_ACK;
            after_ack <= ST_RDATA;
          end
        end
        default: drive_low <= 1'b0;
      endcase
    end
  end

  // Register array: OTP load and bus writes
  wire wr_commit = link_ok && !start_c && !stop_c && st == ST_WDATA && scl_fe && bitn == 4'(BYTE_BITS);
  always_ff @(posedge sys_clk) begin
    if (mode == PRI_OTP_LOAD) begin
      regs[otp_idx] <= (otp_data & otp_mask) | (OTP_DEFAULT & ~otp_mask);
    end else if (wr_commit) begin
      regs[index] <= shreg;
    end
  end

  // no drive under lockout, raw level cuts at once
  assign link.sda_o_s    = 1'b0;
  assign link.sda_oe_n_s = ~(drive_low & supply_ok & link_ok);
endmodule
`default_nettype wire

// ---- verilog/pri_master.sv ----
/*
  Host end: bus master for the serial register port. Makes the link clock
  by dividing sys_clk, runs one write or one index-then-read per request.
*/
`timescale 1ns/1ps
`default_nettype none
module pri_master
  import pri_pkg::*;
#(
  parameter int HALF = HALF_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       req,
  input  wire logic       rd,
  input  wire logic [7:0] index,
  input  wire logic [7:0] wdata,
  output logic            busy,
  output logic            done,
  output logic            nacked,
  output logic [7:0]      rdata,
  pri_link_if.master      link
);
  typedef enum {M_IDLE, M_START, M_BITS, M_STOP, M_FIN} pri_mst_t;
  pri_mst_t  st;
  logic [15:0] div;
  logic [1:0]  ph;
  logic [3:0]  bitn;
  logic [1:0]  byten;
  logic [8:0]  sh;
  logic        scl_lo;
  logic        sda_lo;
  logic        rphase;
  logic        rd_q;
  logic [7:0]  idx_q;
  logic [7:0]  wd_q;
  wire tick = (div == 16'(HALF / 2 - 1));
  wire sda_in = link.sda;

  // Quarter-period enable divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
    end else begin
      div <= tick ? '0 : div + 1'b1;
    end
  end

  // master alone frames START and STOP
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st     <= M_IDLE;
      ph     <= '0;
      bitn   <= '0;
      byten  <= '0;
      sh     <= '0;
      scl_lo <= 1'b0;
      sda_lo <= 1'b0;
      rphase <= 1'b0;
      rd_q   <= 1'b0;
      idx_q  <= '0;
      wd_q   <= '0;
      done   <= 1'b0;
      nacked <= 1'b0;
      rdata  <= '0;
    end else begin
      done <= 1'b0;
      case (st)
        M_IDLE: begin
          if (req) begin
            rd_q   <= rd;
            idx_q  <= index;
            wd_q   <= wdata;
            rphase <= 1'b0;
            nacked <= 1'b0;
            st     <= M_START;
            ph     <= '0;
          end
        end
        M_START: begin
          if (tick) begin
            ph <= ph + 1'b1;
            case (ph)
              // free data line; clock is still low only on a repeated start
              2'd0: sda_lo <= 1'b0;
              2'd1: scl_lo <= 1'b0;
              // Data falls with clock high
              2'd2: sda_lo <= 1'b1;
              default: begin
                scl_lo <= 1'b1;
                sh     <= {DEV_ADDR, rphase, 1'b1};
                bitn   <= '0;
                byten  <= '0;
                st     <= M_BITS;
              end
            endcase
          end
        end
        M_BITS: begin
          if (tick) begin
            ph <= ph + 1'b1;
            case (ph)
              2'd0: sda_lo <= ~sh[8];
              2'd1: scl_lo <= 1'b0;
              2'd2: begin
                if (bitn == 4'd8) begin
                  if (sda_in && !(rphase && byten == 2'd1)) begin
                    nacked <= 1'b1;
                  end
                end else if (rphase && byten == 2'd1) begin
                  rdata <= {rdata[6:0], sda_in};
                end
              end
              default: begin
                scl_lo <= 1'b1;
                sh     <= {sh[7:0], 1'b1};
                bitn   <= bitn + 1'b1;
                if (bitn == 4'd8) begin
                  bitn  <= '0;
                  byten <= byten + 1'b1;
                  if (nacked) begin
                    st <= M_STOP;
                  end else if (byten == 2'd1 && rd_q && !rphase) begin
                    rphase <= 1'b1;
                    st     <= M_START;
                  // Single read byte taken, stop
                  end else if (byten == 2'd1 && rphase) begin
                    st <= M_STOP;
                  end else if (byten == 2'd2) begin
                    st <= M_STOP;
                  end else if (rphase) begin
                    sh <= 9'h1ff;
                  end else begin
                    sh <= (byten == 2'd0) ? {idx_q, 1'b1} : {wd_q, 1'b1};
                  end
                end else if (bitn == 4'd7) begin
                  // leave ack slot high on last read
                  sh <= (rphase && byten == 2'd1) ? 9'h1ff : {sh[7:0], 1'b1};
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            ph <= ph + 1'b1;
            case (ph)
              2'd0: sda_lo <= 1'b1;
              2'd1: scl_lo <= 1'b0;
              2'd2: sda_lo <= 1'b0;
              default: st <= M_FIN;
            endcase
          end
        end
        default: begin
          done <= 1'b1;
          st   <= M_IDLE;
        end
      endcase
    end
  end

  assign busy = (st != M_IDLE);
  assign link.scl_o_m    = 1'b0;
  assign link.scl_oe_n_m = ~scl_lo;
  assign link.sda_o_m    = 1'b0;
  assign link.sda_oe_n_m = ~sda_lo;
endmodule
`default_nettype wire

// ---- verification/pri_link_chk.sv ----
/*
  Checker for the two-wire link between master and slave port.
  Assumes the master clock is a clean divider of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pri_link_chk
  import pri_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic scl_oe_n_m,
  input wire logic sda_oe_n_m,
  input wire logic sda_oe_n_s,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic       rdir;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  // Edge and condition decode
  wire        rise  = scl & ~scl_q;
  wire        start = scl & scl_q & sda_q & ~sda;
  wire        stop  = scl & scl_q & ~sda_q & sda;
  wire        ninth = rise & (bitcnt == 4'h8);
  // Bit count, byte shift, direction
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first <= 1'b0;
      rdir <= 1'b0;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        bitcnt <= 4'h0;
        first <= 1'b1;
      end else if (rise) begin
        bitcnt <= ninth ? 4'h0 : bitcnt + 4'h1;
      end
      if (rise && !ninth) begin
        shreg <= {shreg[6:0], sda};
      end
      if (ninth && first) begin
        rdir <= shreg[0];
        first <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_lock; (!supply_ok) [*2]; endsequence
  sequence s_idle; scl [*4]; endsequence
  property p_slave_hold; scl && scl_q |-> $stable(sda_oe_n_s); endproperty
  property p_cond_master; start || stop |-> sda_oe_n_s; endproperty
  property p_lock; s_lock |-> sda_oe_n_s; endproperty
  property p_ack_addr; ninth && first && shreg[7:1] == DEV_ADDR && supply_ok |-> !sda; endproperty
  property p_ack_data; ninth && !first && !rdir && supply_ok |-> !sda; endproperty
  property p_rel_ack; ninth && first |-> sda_oe_n_m; endproperty
  property p_addr; ninth && first |-> shreg[7:1] == DEV_ADDR; endproperty
  property p_frame; stop |-> bitcnt == 4'h1; endproperty
  property p_nack; ninth && !first && rdir |-> sda_oe_n_m && sda; endproperty
  property p_idle; stop |=> s_idle; endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("slave data moved with clock high");
  a_cond_master: assert property (p_cond_master) else $error("start or stop while slave drives");
  a_lock: assert property (p_lock) else $error("data driven under lockout");
  a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");
  a_ack_data: assert property (p_ack_data) else $error("written byte not acknowledged");
  a_rel_ack: assert property (p_rel_ack) else $error("master held data in ack slot");
  a_addr: assert property (p_addr) else $error("wrong bus address sent");
  a_frame: assert property (p_frame) else $error("stop inside a byte");
  a_nack: assert property (p_nack) else $error("last read byte acknowledged");
  a_idle: assert property (p_idle) else $error("clock not at rest after stop");
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
/*
  Bench: master and slave port joined by the link, driven from the
  master's request side. Assumes the design package is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t %s", $time, m); end end
module tb_top
  import pri_pkg::*;
;
  localparam logic [7:0] OTPD = 8'h5e;
  localparam logic [7:0] OTPM = 8'hfc;
  localparam logic [7:0] REN  = 8'h09;
  logic       sys_clk;
  logic       rst_n;
  logic       supply_ok;
  logic       req;
  logic       rd;
  logic [7:0] index;
  logic [7:0] wdata;
  logic       busy;
  logic       done;
  logic       nacked;
  logic [7:0] rdata;
  logic       regs_enabled;
  pri_mode_t  mode;
  int         bad_count;
  int         comparisons;
  pri_link_if link();
  pri_master #(.HALF(8)) i_pri_master (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rd(rd), .index(index),
    .wdata(wdata), .busy(busy), .done(done), .nacked(nacked), .rdata(rdata), .link(link));
  pri_slave #(.OTP_CYCLES(2)) i_pri_slave (.sys_clk(sys_clk), .rst_n(rst_n), .supply_ok(supply_ok),
    .otp_data(OTPD), .otp_mask(OTPM), .reg_enables_idx(REN), .regs_enabled(regs_enabled), .mode(mode),
    .otp_idx(), .link(link));
  pri_link_chk chk (.sys_clk(sys_clk), .rst_n(rst_n), .supply_ok(supply_ok), .scl_oe_n_m(link.scl_oe_n_m),
    .sda_oe_n_m(link.sda_oe_n_m), .sda_oe_n_s(link.sda_oe_n_s), .scl(link.scl), .sda(link.sda));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Verdict and stop
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One request, wait for completion
  task automatic xfer(input logic r, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(negedge sys_clk);
    req = 1'b1;
    rd = r;
    index = i;
    wdata = d;
    @(negedge sys_clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(done, 1'b1, "no done")
  endtask
  task automatic t_lock;
    supply_ok = 1'b0;
    repeat (6) @(negedge sys_clk);
    `CHK(mode, PRI_SHUTDOWN, "not shut down")
    `CHK(regs_enabled, 1'b0, "regulator on")
    xfer(1'b0, 8'h03, 8'h11);
    `CHK(nacked, 1'b1, "acked in lockout")
    $display("t_lock done");
  endtask
  task automatic t_boot;
    int n;
    supply_ok = 1'b1;
    n = 0;
    while (mode !== PRI_STANDBY && n < 300) begin
      @(negedge sys_clk);
      n++;
      `CHK(regs_enabled, 1'b0, "regulator on in load")
    end
    `CHK(mode, PRI_STANDBY, "no standby")
    xfer(1'b1, 8'h07, 8'h00);
    `CHK(nacked, 1'b0, "read nacked")
    `CHK(rdata, OTPD & OTPM, "load value")
    $display("t_boot done");
  endtask
  task automatic t_rw;
    xfer(1'b0, 8'h03, 8'ha5);
    `CHK(nacked, 1'b0, "write nacked")
    xfer(1'b0, 8'h04, 8'h3c);
    xfer(1'b1, 8'h03, 8'h00);
    `CHK(rdata, 8'ha5, "read 03")
    xfer(1'b1, 8'h03, 8'h00);
    `CHK(rdata, 8'ha5, "reread 03")
    xfer(1'b1, 8'h04, 8'h00);
    `CHK(rdata, 8'h3c, "read 04")
    xfer(1'b1, 8'h1f, 8'h00);
    `CHK(rdata, OTPD & OTPM, "read 1f")
    $display("t_rw done");
  endtask
  task automatic t_active;
    xfer(1'b0, REN, 8'h02);
    repeat (4) @(negedge sys_clk);
    `CHK(mode, PRI_ACTIVE, "not active")
    `CHK(regs_enabled, 1'b1, "regulator off")
    xfer(1'b1, REN, 8'h00);
    `CHK(rdata, 8'h02, "read in active")
    xfer(1'b0, REN, 8'h00);
    repeat (4) @(negedge sys_clk);
    `CHK(mode, PRI_STANDBY, "not back to standby")
    $display("t_active done");
  endtask
  // Main sequence
  initial begin
    bad_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    supply_ok = 1'b0;
    req = 1'b0;
    rd = 1'b0;
    index = 8'h00;
    wdata = 8'h00;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    t_lock;
    t_boot;
    t_rw;
    t_active;
    t_lock;
    end_sim;
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge sys_clk);
    bad_count++;
    end_sim;
  end
endmodule
`default_nettype wire
